// ===== core/led_pwm_pkg.sv
// Package for the two-channel LED sink driver: register map, field layout,
// reset values, timebase figures and the decode helpers shared by both files.
// Assumes a 125 MHz pclk and an APB master with 32-bit data.
package led_pwm_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] RED_OFS    = 8'h04;
  localparam logic [7:0] GREEN_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;

  // Control register fields
  localparam int RED_EN_BIT   = 0;
  localparam int GREEN_EN_BIT = 1;
  localparam int OVERRIDE_BIT = 2;
  localparam int CTRL_W       = 3;

  // Status register fields
  localparam int ST_RED_ACT_LSB   = 0;
  localparam int ST_GREEN_ACT_LSB = 8;
  localparam int ST_RED_RAMP      = 16;
  localparam int ST_GREEN_RAMP    = 17;
  localparam int ST_RED_DRV       = 18;
  localparam int ST_GREEN_DRV     = 19;
  localparam int ST_THERMAL       = 20;

  // Channel configuration word, bits [10:0] of RED / GREEN
  typedef struct packed {
    logic       ramp;     // [10]
    logic [1:0] period;   // [9:8]
    logic [5:0] duty;     // [7:2]
    logic [1:0] level;    // [1:0]
  } chan_cfg_s;
  localparam int CFG_W = 11;

  // Level codes: 00 3.5 mA, 01 7.0 mA, 10 10 mA, 11 12 mA
  localparam logic [1:0] LEVEL_RESET = 2'h1;
  localparam chan_cfg_s  CFG_RESET   = '{ramp: 1'b0, period: 2'h0, duty: 6'h00, level: LEVEL_RESET};
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

  // Period codes
  localparam logic [1:0] PER_256HZ = 2'h0;
  localparam logic [1:0] PER_8HZ   = 2'h1;
  localparam logic [1:0] PER_1HZ   = 2'h2;

  // Thermal input level that allows the sinks to drive
  localparam logic THERMAL_CONDITION_BIT_PERMIT = 1'b0;

  // ------------------------------------------------------------------
  // Timebase
  // ------------------------------------------------------------------
  localparam int CLK_HZ        = 125_000_000;
  localparam int BASE_RATE_HZ  = 256;
  localparam int SLOTS         = 32;
  localparam int RAMP_RATE_HZ  = 64;
  localparam int SLOT_CYCLES   = CLK_HZ / (BASE_RATE_HZ * SLOTS);
  localparam int RAMP_SHIFT    = $clog2(SLOTS * BASE_RATE_HZ / RAMP_RATE_HZ);
  localparam int SHIFT_8HZ     = $clog2(BASE_RATE_HZ / 8);
  localparam int SHIFT_1HZ     = $clog2(BASE_RATE_HZ / 1);
  localparam int SHIFT_HALFHZ  = $clog2(BASE_RATE_HZ * 2);
  localparam int PRESC_W       = SHIFT_HALFHZ + 5;
  localparam logic [5:0] FULL_ON = 6'h20;

  // Slot prescaler shift for a period code
  function automatic int period_shift(input logic [1:0] per);
    case (per)
      PER_256HZ: period_shift = 0;
      PER_8HZ:   period_shift = SHIFT_8HZ;
      PER_1HZ:   period_shift = SHIFT_1HZ;
      default:   period_shift = SHIFT_HALFHZ;
    endcase
  endfunction : period_shift

  // Duty code to on-slots, 0..32
  function automatic logic [5:0] duty_level(input logic [5:0] code);
    duty_level = code[5] ? FULL_ON : {1'b0, code[4:0]};
  endfunction : duty_level

endpackage : led_pwm_pkg

// ===== core/led_pwm_channel.sv
// One LED sink channel: active duty tracking, ramp stepping and slot compare.
// Assumes base_tick pulses once per slot of the 256 Hz period and presc
// counts those ticks, shared with the other channel.
`timescale 1ns/1ps
module led_pwm_channel (
  // Clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // Shared timebase
  input  wire logic                            base_tick,
  input  wire logic [led_pwm_pkg::PRESC_W-1:0] presc,
  // Settings
  input  wire led_pwm_pkg::chan_cfg_s          cfg,
  // State
  output logic      [5:0]                      active,
  output logic                                 ramping,
  output logic                                 pwm_on
);

  // ------------------------------------------------------------------
  // Timebase decode
  // ------------------------------------------------------------------
  logic [5:0]                      active_ff;
  logic [5:0]                      nxt_active;
  logic                            pwm_on_ff;
  logic [5:0]                      target;
  logic                            ramp_eff;
  logic                            boundary;
  logic                            ramp_tick;
  logic [led_pwm_pkg::PRESC_W-1:0] pmask;
  logic [led_pwm_pkg::PRESC_W-1:0] pshift;
  logic [4:0]                      slot;

  // Period mask, slot position and ramp tick
  assign pmask     = led_pwm_pkg::PRESC_W'((1 << (led_pwm_pkg::period_shift(cfg.period) + 5)) - 1);
  assign pshift    = presc >> led_pwm_pkg::period_shift(cfg.period);
  assign slot      = pshift[4:0];
  assign boundary  = base_tick & ((presc & pmask) == pmask);
  assign ramp_tick = base_tick & (&presc[led_pwm_pkg::RAMP_SHIFT-1:0]);
  assign target    = led_pwm_pkg::duty_level(cfg.duty);
  // [R5] ramp only at 256 Hz
  assign ramp_eff  = cfg.ramp & (cfg.period == led_pwm_pkg::PER_256HZ);

  // ------------------------------------------------------------------
  // Active duty
  // ------------------------------------------------------------------
  // Next active duty from ramp or direct load
  always_comb begin
    nxt_active = active_ff;
    // [R6] one step per tick
    if (ramp_eff && ramp_tick) begin
      // [R7] [R11] chase newest target
      if (active_ff < target)
        nxt_active = active_ff + 6'h01;
      else if (active_ff > target)
        nxt_active = active_ff - 6'h01;
    // [R8] [R10] direct load at boundary
    end else if (!ramp_eff && boundary) begin
      nxt_active = target;
    end
  end

  // Active duty register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      active_ff <= 6'h00;
    else
      active_ff <= nxt_active;
  end

  // [R4] [R9] slot compare within the period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pwm_on_ff <= 1'b0;
    else
      pwm_on_ff <= (active_ff == led_pwm_pkg::FULL_ON) || ({1'b0, slot} < active_ff);
  end

  assign active  = active_ff;
  assign pwm_on  = pwm_on_ff;
  assign ramping = ramp_eff & (active_ff != target);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_ramp_step_size: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    $past(ramp_eff) && ramp_eff |-> (active_ff - $past(active_ff) <= 6'h01)
      || ($past(active_ff) - active_ff <= 6'h01))
    else $error("ramp moved active duty by more than one step");

  a_ramp_only_tick: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    ramp_eff && !ramp_tick |=> $stable(active_ff))
    else $error("ramped duty changed outside a ramp tick");

  a_direct_load: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
    !ramp_eff && boundary |=> active_ff == $past(target))
    else $error("direct duty not loaded at period boundary");

  a_zero_is_off: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    active_ff == 6'h00 |=> !pwm_on_ff)
    else $error("zero duty drove the output");

  a_full_is_on: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    active_ff == led_pwm_pkg::FULL_ON |=> pwm_on_ff)
    else $error("full duty did not hold the output on");

  c_ramp_up: cover property (@(posedge pclk) disable iff (!presetn)
    ramp_eff && ramp_tick && active_ff < target);
  c_ramp_down: cover property (@(posedge pclk) disable iff (!presetn)
    ramp_eff && ramp_tick && active_ff > target);

endmodule : led_pwm_channel

// ===== core/led_pwm_ramp_blink_driver.sv
// Two-channel LED sink control: APB register file, shared slot timebase,
// red and green channels, and the output gating toward the sink drivers.
// Assumes an APB master on pclk and a thermal flag arriving from another
// domain, which is synchronised here.
//
// Behaviour
// [R1] Sink drives only with channel enable, override, thermal permit and non-zero duty.
// [R2] Red and green channels have separate settings and do not interact.
// [R3] Two-bit current level code per channel, reset value 01.
// [R4] Six-bit duty: n/32 on-time, zero off, top bit continuously on.
// [R5] Per-channel ramp enable acts only at the 256 Hz period.
// [R6] Ramp moves active duty one 1/32 step every 1/64 second.
// [R7] With ramp on, each new duty sweeps from the present active duty.
// [R8] With ramp off, a new duty applies without a sweep.
// [R9] Two-bit period code: 256, 8, 1 or 1/2 Hz repetition.
// [R10] Periods of 32 slots from a common timebase; duty changes at boundaries.
// [R11] A target change mid-ramp continues from the present active duty.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module led_pwm_ramp_blink_driver #(
  parameter int SLOT_CYCLES = led_pwm_pkg::SLOT_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Thermal flag from the temperature monitor
  input  wire logic        thermal_condition_bit,
  // Red sink channel
  output logic             red_sink_channel,
  output logic      [1:0]  red_level,
  // Green sink channel
  output logic             green_sink_channel,
  output logic      [1:0]  green_level
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [led_pwm_pkg::CTRL_W-1:0]  ctrl_ff;
  led_pwm_pkg::chan_cfg_s          red_cfg_ff;
  led_pwm_pkg::chan_cfg_s          green_cfg_ff;
  logic [31:0]                     prdata_ff;
  logic                            pready_ff;
  logic                            pslverr_ff;
  logic                            thermal_condition_bit_meta_ff;
  logic                            thermal_condition_bit_sync_ff;
  logic [15:0]                     tick_cnt_ff;
  logic                            base_tick_ff;
  logic [led_pwm_pkg::PRESC_W-1:0] presc_ff;
  logic                            red_drv_ff;
  logic                            green_drv_ff;
  logic [1:0]                      red_level_ff;
  logic [1:0]                      green_level_ff;
  logic [5:0]                      red_active;
  logic [5:0]                      green_active;
  logic                            red_ramping;
  logic                            green_ramping;
  logic                            red_pwm;
  logic                            green_pwm;
  logic                            access;
  logic                            wr_done;
  logic                            mapped;
  logic                            permit;
  logic [31:0]                     rd_word;

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  // Access phase, one wait state, completion edge
  assign access  = psel & penable;
  assign wr_done = access & pready_ff & pwrite & mapped;
  assign mapped  = (paddr == led_pwm_pkg::CTRL_OFS) || (paddr == led_pwm_pkg::RED_OFS)
                || (paddr == led_pwm_pkg::GREEN_OFS) || (paddr == led_pwm_pkg::STATUS_OFS);

  // Read data selection
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      led_pwm_pkg::CTRL_OFS:  rd_word[led_pwm_pkg::CTRL_W-1:0] = ctrl_ff;
      led_pwm_pkg::RED_OFS:   rd_word[led_pwm_pkg::CFG_W-1:0]  = red_cfg_ff;
      led_pwm_pkg::GREEN_OFS: rd_word[led_pwm_pkg::CFG_W-1:0]  = green_cfg_ff;
      led_pwm_pkg::STATUS_OFS: begin
        rd_word[led_pwm_pkg::ST_RED_ACT_LSB +: 6]   = red_active;
        rd_word[led_pwm_pkg::ST_GREEN_ACT_LSB +: 6] = green_active;
        rd_word[led_pwm_pkg::ST_RED_RAMP]           = red_ramping;
        rd_word[led_pwm_pkg::ST_GREEN_RAMP]         = green_ramping;
        rd_word[led_pwm_pkg::ST_RED_DRV]            = red_drv_ff;
        rd_word[led_pwm_pkg::ST_GREEN_DRV]          = green_drv_ff;
        rd_word[led_pwm_pkg::ST_THERMAL]            = thermal_condition_bit_sync_ff;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Ready, error and read data, raised in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= access & ~pready_ff;
      pslverr_ff <= access & ~pready_ff & ~mapped;
      if (access && !pready_ff && !pwrite)
        prdata_ff <= rd_word;
    end
  end

  // Control register: enables and override
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_ff <= led_pwm_pkg::CTRL_RESET;
    else if (wr_done && paddr == led_pwm_pkg::CTRL_OFS)
      ctrl_ff <= pwdata[led_pwm_pkg::CTRL_W-1:0];
  end

  // [R2] [R3] separate channel settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      red_cfg_ff   <= led_pwm_pkg::CFG_RESET;
      green_cfg_ff <= led_pwm_pkg::CFG_RESET;
    end else begin
      if (wr_done && paddr == led_pwm_pkg::RED_OFS)
        red_cfg_ff <= led_pwm_pkg::chan_cfg_s'(pwdata[led_pwm_pkg::CFG_W-1:0]);
      if (wr_done && paddr == led_pwm_pkg::GREEN_OFS)
        green_cfg_ff <= led_pwm_pkg::chan_cfg_s'(pwdata[led_pwm_pkg::CFG_W-1:0]);
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // ------------------------------------------------------------------
  // Thermal synchroniser
  // ------------------------------------------------------------------
  // Two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thermal_condition_bit_meta_ff <= 1'b0;
      thermal_condition_bit_sync_ff <= 1'b0;
    end else begin
      thermal_condition_bit_meta_ff <= thermal_condition_bit;
      thermal_condition_bit_sync_ff <= thermal_condition_bit_meta_ff;
    end
  end

  assign permit = (thermal_condition_bit_sync_ff == led_pwm_pkg::THERMAL_CONDITION_BIT_PERMIT);

  // ------------------------------------------------------------------
  // Shared timebase
  // ------------------------------------------------------------------
  // [R10] slot ticks and slot prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff  <= 16'h0000;
      base_tick_ff <= 1'b0;
      presc_ff     <= '0;
    end else begin
      base_tick_ff <= (tick_cnt_ff == 16'(SLOT_CYCLES - 1));
      if (tick_cnt_ff == 16'(SLOT_CYCLES - 1))
        tick_cnt_ff <= 16'h0000;
      else
        tick_cnt_ff <= tick_cnt_ff + 16'h0001;
      if (base_tick_ff)
        presc_ff <= presc_ff + led_pwm_pkg::PRESC_W'(1);
    end
  end

  // ------------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------------
  // [R2] red channel
  led_pwm_channel u_red (
    .pclk      (pclk),
    .presetn   (presetn),
    .base_tick (base_tick_ff),
    .presc     (presc_ff),
    .cfg       (red_cfg_ff),
    .active    (red_active),
    .ramping   (red_ramping),
    .pwm_on    (red_pwm)
  );

  // [R2] green channel
  led_pwm_channel u_green (
    .pclk      (pclk),
    .presetn   (presetn),
    .base_tick (base_tick_ff),
    .presc     (presc_ff),
    .cfg       (green_cfg_ff),
    .active    (green_active),
    .ramping   (green_ramping),
    .pwm_on    (green_pwm)
  );

  // ------------------------------------------------------------------
  // Output gating
  // ------------------------------------------------------------------
  // [R1] drive gate per channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      red_drv_ff   <= 1'b0;
      green_drv_ff <= 1'b0;
    end else begin
      red_drv_ff   <= ctrl_ff[led_pwm_pkg::RED_EN_BIT] & ctrl_ff[led_pwm_pkg::OVERRIDE_BIT]
                    & permit & (red_active != 6'h00) & red_pwm;
      green_drv_ff <= ctrl_ff[led_pwm_pkg::GREEN_EN_BIT] & ctrl_ff[led_pwm_pkg::OVERRIDE_BIT]
                    & permit & (green_active != 6'h00) & green_pwm;
    end
  end

  // [R3] current level codes to the sinks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      red_level_ff   <= led_pwm_pkg::LEVEL_RESET;
      green_level_ff <= led_pwm_pkg::LEVEL_RESET;
    end else begin
      red_level_ff   <= red_cfg_ff.level;
      green_level_ff <= green_cfg_ff.level;
    end
  end

  assign red_sink_channel   = red_drv_ff;
  assign green_sink_channel = green_drv_ff;
  assign red_level          = red_level_ff;
  assign green_level        = green_level_ff;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_red_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    red_drv_ff |-> $past(ctrl_ff[led_pwm_pkg::RED_EN_BIT]) && $past(ctrl_ff[led_pwm_pkg::OVERRIDE_BIT])
      && $past(permit) && $past(red_active) != 6'h00)
    else $error("red sink driven without all permits");

  a_green_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    green_drv_ff |-> $past(ctrl_ff[led_pwm_pkg::GREEN_EN_BIT]) && $past(ctrl_ff[led_pwm_pkg::OVERRIDE_BIT])
      && $past(permit) && $past(green_active) != 6'h00)
    else $error("green sink driven without all permits");

  a_level_follows: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    ##1 red_level_ff == $past(red_cfg_ff.level) && green_level_ff == $past(green_cfg_ff.level))
    else $error("level output does not follow its code");

  a_chan_isolated: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    wr_done && paddr == led_pwm_pkg::RED_OFS |=> $stable(green_cfg_ff))
    else $error("red write disturbed green settings");

  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready_ff |=> pready_ff ##1 !pready_ff)
    else $error("apb answer not after one wait state");

  a_slot_period: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    base_tick_ff |-> tick_cnt_ff == 16'h0000 && $past(tick_cnt_ff) == 16'(SLOT_CYCLES - 1))
    else $error("slot tick not one per slot interval");

  c_red_on: cover property (@(posedge pclk) disable iff (!presetn) red_drv_ff);
  c_both_on: cover property (@(posedge pclk) disable iff (!presetn) red_drv_ff && green_drv_ff);
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr_ff);

endmodule : led_pwm_ramp_blink_driver

// ===== tb/led_sink_model.sv
// LED sink model: counts the clocks in which one sink output is on.
// Assumes the sink output is a registered level on pclk.
`timescale 1ns/1ps
module led_sink_model (
  // Clock
  input  wire logic        pclk,
  // Sink output and window clear
  input  wire logic        sink,
  input  wire logic        clr,
  // Lit clocks since the last clear
  output logic      [31:0] on_cnt
);
  // Lit-clock counter, restarted by clr
  always_ff @(posedge pclk) begin
    if (clr) begin
      on_cnt <= 32'h0;
    end else if (sink) begin
      on_cnt <= on_cnt + 32'h1;
    end
  end
endmodule : led_sink_model

// ===== tb/tb_led_pwm_ramp_blink_driver.sv
// Testbench for the two-channel LED sink driver: APB tasks, lit-time
// measurement through two sink models, ramp and blink timing.
// Assumes a short slot parameter so that the slow periods fit the run.
`timescale 1ns/1ps
module tb_led_pwm_ramp_blink_driver;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  localparam int SC   = 4;
  localparam int PER  = 32 * SC;
  localparam int STEP = 128 * SC;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, clr;
  logic        thermal_condition_bit, red_sink_channel, green_sink_channel;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata, r_cnt, g_cnt;
  logic [1:0]  red_level, green_level;
  logic [5:0]  dt [6] = '{6'h00, 6'h01, 6'h08, 6'h1F, 6'h20, 6'h3F};
  int          ex [6] = '{0, 1, 8, 31, 32, 32};
  int          errors, num_checks, n, t0, dly;

  // Design and the two sink models
  led_pwm_ramp_blink_driver #(.SLOT_CYCLES(SC)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .thermal_condition_bit(thermal_condition_bit), .red_sink_channel(red_sink_channel),
    .red_level(red_level), .green_sink_channel(green_sink_channel), .green_level(green_level));
  led_sink_model i_red (.pclk(pclk), .sink(red_sink_channel), .clr(clr), .on_cnt(r_cnt));
  led_sink_model i_green (.pclk(pclk), .sink(green_sink_channel), .clr(clr), .on_cnt(g_cnt));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk

  // One APB transfer; read data and error are taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1, "no pready");
  endtask : apb

  // Count lit clocks of both sinks over a window
  task automatic meas(input int cyc);
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (cyc) @(posedge pclk);
    #1;
  endtask : meas

  // Channel configuration word
  function automatic logic [31:0] cw(input logic r, input logic [1:0] p, input logic [5:0] du,
                                     input logic [1:0] l);
    cw = {21'h0, r, p, du, l};
  endfunction : cw

  // Verdict
  task automatic test_done();
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // Watchdog
  initial begin
    repeat (60000) @(posedge pclk);
    errors++;
    test_done();
  end

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, clr, thermal_condition_bit} = 6'h0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk({30'h0, red_level}, 32'h1, "red level reset");
    apb(1'b0, led_pwm_pkg::CTRL_OFS, 32'h0);
    chk(rdata, 32'h0, "ctrl reset");
    apb(1'b0, led_pwm_pkg::RED_OFS, 32'h0);
    chk(rdata, 32'h1, "red cfg reset");
    apb(1'b0, led_pwm_pkg::STATUS_OFS, 32'h0);
    chk(rdata, 32'h0, "status reset");
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped error");
    chk(rdata, 32'h0, "unmapped data");
    // Level codes on red only
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, led_pwm_pkg::RED_OFS, cw(1'b0, 2'h0, 6'h00, 2'(i)));
      @(posedge pclk);
      #1;
      chk({30'h0, red_level}, 32'(i), "red level");
      chk({30'h0, green_level}, 32'h1, "green level disturbed");
    end
    // Duty codes at 256 Hz, red enabled with override
    apb(1'b1, led_pwm_pkg::CTRL_OFS, 32'h5);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, led_pwm_pkg::RED_OFS, cw(1'b0, 2'h0, dt[i], 2'h1));
      repeat (300) @(posedge pclk);
      apb(1'b0, led_pwm_pkg::STATUS_OFS, 32'h0);
      chk({26'h0, rdata[5:0]}, 32'(ex[i]), "direct duty load");
      meas(PER);
      chk(r_cnt, 32'(ex[i] * SC), "red lit time");
      chk(g_cnt, 32'h0, "green lit while disabled");
    end
    // Gating: thermal, override, enable
    apb(1'b1, led_pwm_pkg::RED_OFS, cw(1'b0, 2'h0, 6'h08, 2'h1));
    for (int j = 0; j < 3; j++) begin
      @(posedge pclk) thermal_condition_bit <= (j == 0);
      apb(1'b1, led_pwm_pkg::CTRL_OFS, (j == 0) ? 32'h5 : (j == 1) ? 32'h1 : 32'h4);
      repeat (300) @(posedge pclk);
      apb(1'b0, led_pwm_pkg::STATUS_OFS, 32'h0);
      chk({31'h0, rdata[20]}, 32'(j == 0), "thermal status");
      chk({31'h0, rdata[18]}, 32'h0, "red drive status");
      meas(PER);
      chk(r_cnt, 32'h0, "gated sink lit");
    end
    @(posedge pclk) thermal_condition_bit <= 1'b0;
    apb(1'b1, led_pwm_pkg::CTRL_OFS, 32'h7);
    apb(1'b1, led_pwm_pkg::GREEN_OFS, cw(1'b0, 2'h0, 6'h10, 2'h1));
    repeat (300) @(posedge pclk);
    meas(PER);
    chk(r_cnt, 32'(8 * SC), "red with green on");
    chk(g_cnt, 32'(16 * SC), "green lit time");
    // Ramp up, redirected downward mid-ramp
    apb(1'b1, led_pwm_pkg::RED_OFS, cw(1'b1, 2'h0, 6'h0C, 2'h1));
    repeat (100) @(posedge pclk);
    apb(1'b0, led_pwm_pkg::STATUS_OFS, 32'h0);
    chk({31'h0, rdata[16]}, 32'h1, "ramping flag");
    chk({31'h0, rdata[5:0] < 6'h0C}, 32'h1, "ramp jumped");
    apb(1'b1, led_pwm_pkg::RED_OFS, cw(1'b1, 2'h0, 6'h06, 2'h1));
    repeat (5 * STEP) @(posedge pclk);
    apb(1'b0, led_pwm_pkg::STATUS_OFS, 32'h0);
    chk({15'h0, rdata[16], 10'h0, rdata[5:0]}, 32'h6, "redirected ramp end");
    // Four steps take three to four step intervals
    apb(1'b1, led_pwm_pkg::RED_OFS, cw(1'b1, 2'h0, 6'h0A, 2'h1));
    t0 = int'($time);
    n  = 0;
    do begin
      apb(1'b0, led_pwm_pkg::STATUS_OFS, 32'h0);
      n++;
    end while (rdata[5:0] !== 6'h0A && n < 1000);
    dly = (int'($time) - t0) / 8;
    chk({31'h0, dly >= 3 * STEP && dly <= 4 * STEP + 64}, 32'h1, "ramp step time");
    // Ramp bit ignored at 8 Hz, then blink lit time
    apb(1'b1, led_pwm_pkg::RED_OFS, cw(1'b1, 2'h1, 6'h20, 2'h1));
    repeat (PER * 32 + 300) @(posedge pclk);
    apb(1'b0, led_pwm_pkg::STATUS_OFS, 32'h0);
    chk({15'h0, rdata[16], 10'h0, rdata[5:0]}, 32'h20, "ramp at slow rate");
    apb(1'b1, led_pwm_pkg::RED_OFS, cw(1'b0, 2'h1, 6'h10, 2'h1));
    repeat (PER * 32 + 300) @(posedge pclk);
    meas(PER * 32);
    chk(r_cnt, 32'(16 * SC * 32), "blink lit time");
    chk(g_cnt, 32'(16 * SC * 32), "green kept its rate");
    // Remaining period codes read back
    for (int i = 2; i < 4; i++) begin
      apb(1'b1, led_pwm_pkg::GREEN_OFS, cw(1'b0, 2'(i), 6'h10, 2'h1));
      apb(1'b0, led_pwm_pkg::GREEN_OFS, 32'h0);
      chk(rdata, cw(1'b0, 2'(i), 6'h10, 2'h1), "period code");
    end
    test_done();
  end
endmodule : tb_led_pwm_ramp_blink_driver
